/* File: src/lwd_pkg.sv */
/*
  Constants for the write frame decoder of a LIN RGB LED node: identifiers,
  frame lengths, field positions, OTP byte map, register map and states.
  Assumes a single clock domain and a byte-level LIN receiver in front.
*/
package lwd_pkg;
  // protected identifiers of the write frames
  localparam logic [7:0] ID_FULL_COLOR  = 8'h64;
  localparam logic [7:0] ID_SHORT_COLOR = 8'h6F;
  localparam logic [7:0] ID_BRIGHT      = 8'h2E;
  localparam logic [7:0] ID_CAL_DIAG    = 8'h25;
  localparam logic [7:0] ID_CAL_OFF     = 8'h76;
  localparam logic [7:0] ID_OTP_WRITE   = 8'hE7;
  localparam logic [7:0] ID_LED_CTRL    = 8'hA3;
  // data bytes per frame, checksum excluded
  localparam logic [3:0] LEN_FULL  = 4'h8;
  localparam logic [3:0] LEN_SHORT = 4'h4;
  localparam logic [3:0] LEN_BRIGHT = 4'h2;
  localparam logic [3:0] LEN_DIAG  = 4'h4;
  localparam logic [3:0] LEN_OFF   = 4'h8;
  localparam logic [3:0] LEN_OTP   = 4'h4;
  localparam logic [3:0] LEN_CTRL  = 4'h4;
  localparam logic [3:0] LEN_NONE  = 4'h0;
  localparam int         BUF_DEPTH = 8;
  localparam logic [7:0] CSUM_GOOD = 8'hFF;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [3:0] NIB_ONES  = 4'hF;
  localparam logic [1:0] PAIR_ONES = 2'h3;
  // field positions
  localparam int BIT_BROAD   = 7;
  localparam int BIT_ONE     = 6;
  localparam int BIT_FADE_EN = 7;
  localparam int BIT_FADE_LIN = 6;
  localparam int BIT_OUT_ON  = 5;
  localparam int BIT_CONST4  = 4;
  localparam int BIT_CAL_EN  = 7;
  localparam int BIT_MODFREQ = 6;
  localparam int BIT_THERMAL = 4;
  localparam int BIT_CONST0  = 0;
  // color update modes
  localparam logic [1:0] MODE_NOW     = 2'h0;
  localparam logic [1:0] MODE_STORE   = 2'h1;
  localparam logic [1:0] MODE_APPLY   = 2'h2;
  localparam logic [1:0] MODE_DISCARD = 2'h3;
  // calibration: coefficient 8'h80 is unity gain
  localparam int CAL_SUM_W = 18;
  localparam int CAL_SHIFT = 7;
  localparam int MOD_W     = 11;
  // OTP byte map and blank-part contents
  localparam int         OTP_DEPTH     = 16;
  localparam logic [3:0] OTP_NODE_IDX  = 4'h0;
  localparam logic [3:0] OTP_GROUP_IDX = 4'h1;
  localparam logic [3:0] OTP_COEF_BASE = 4'h2;
  localparam int         NUM_COEF      = 9;
  localparam logic [7:0] OTP_DEFAULT [OTP_DEPTH] = '{
    8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00,
    8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic       CTRL_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_IDENT = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_EXEC  = 4'b1000
  } lwd_state_t;
endpackage

/* File: src/lwd_decoder.sv */
/*
  Write frame decoder of a LIN RGB LED node, with OTP model, calibration
  matrix and an AXI4-Lite register slave.
  Assumes a LIN receiver that pulses rx_break before each identifier and
  rx_valid with each received byte, all synchronous to aclk.
*/
`timescale 1ns/1ps
module lwd_decoder (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        rx_break,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  output logic [10:0]      led_mod_1,
  output logic [10:0]      led_mod_2,
  output logic [10:0]      led_mod_3,
  output logic [2:0]       led_enable,
  output logic             cal_enable,
  output logic             modulation_frequency_select,
  output logic             outputs_on,
  output logic             thermal_control,
  output logic [3:0]       intensity,
  output logic [5:0]       fade_time,
  output logic             fade_enable,
  output logic             fade_linear,
  output logic             otp_prog_strobe,
  output logic [3:0]       otp_prog_addr,
  output logic [7:0]       otp_prog_data,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

  function automatic logic [3:0] len_of(input logic [7:0] id);
    logic [3:0] n;
    n = lwd_pkg::LEN_NONE;
    case (id)
      lwd_pkg::ID_FULL_COLOR:  n = lwd_pkg::LEN_FULL;
      lwd_pkg::ID_SHORT_COLOR: n = lwd_pkg::LEN_SHORT;
      lwd_pkg::ID_BRIGHT:      n = lwd_pkg::LEN_BRIGHT;
      lwd_pkg::ID_CAL_DIAG:    n = lwd_pkg::LEN_DIAG;
      lwd_pkg::ID_CAL_OFF:     n = lwd_pkg::LEN_OFF;
      lwd_pkg::ID_OTP_WRITE:   n = lwd_pkg::LEN_OTP;
      lwd_pkg::ID_LED_CTRL:    n = lwd_pkg::LEN_CTRL;
      default:                 n = lwd_pkg::LEN_NONE;
    endcase
    return n;
  endfunction

  function automatic logic [10:0] cal_row(input logic [7:0] c1, input logic [7:0] c2,
                                          input logic [7:0] c3, input logic [7:0] v1,
                                          input logic [7:0] v2, input logic [7:0] v3);
    logic [17:0] s;
    s = 18'(c1) * 18'(v1) + 18'(c2) * 18'(v2) + 18'(c3) * 18'(v3);
    // 3 x 255 x 255 fits 18 bits, so the top 11 bits never overflow
    return s[lwd_pkg::CAL_SUM_W-1:lwd_pkg::CAL_SHIFT];
  endfunction

  lwd_pkg::lwd_state_t state_q;
  logic [7:0]  id_q;
  logic [3:0]  len_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sum_q;
  logic        chk_ok_q;
  logic [7:0]  buf_q [lwd_pkg::BUF_DEPTH];
  logic [7:0]  otp_q [lwd_pkg::OTP_DEPTH];
  logic [7:0]  coef_q [lwd_pkg::NUM_COEF];
  logic        load_q;
  logic [7:0]  color_q [3];
  logic [10:0] mod1_q, mod2_q, mod3_q;
  logic [2:0]  led_en_q;
  logic        cal_en_q, mfreq_q, out_on_q, therm_q, fade_en_q, fade_lin_q;
  logic [3:0]  int_q;
  logic [5:0]  ftime_q;
  logic        otp_stb_q;
  logic [3:0]  otp_addr_q;
  logic [7:0]  otp_data_q;
  logic        ctrl_en_q;
  logic [7:0]  acc_cnt_q, rej_cnt_q, last_id_q;
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;

  // frame field decode
  wire [7:0]  d1 = buf_q[0];
  wire [7:0]  d2 = buf_q[1];
  wire [7:0]  d3 = buf_q[2];
  wire [7:0]  d4 = buf_q[3];
  wire [7:0]  d5 = buf_q[4];
  wire [7:0]  d6 = buf_q[5];
  wire [7:0]  d7 = buf_q[6];
  wire [7:0]  d8 = buf_q[7];
  wire [5:0]  node_num   = otp_q[lwd_pkg::OTP_NODE_IDX][5:0];
  wire [3:0]  membership = otp_q[lwd_pkg::OTP_GROUP_IDX][3:0];
  wire [1:0]  color_grp  = membership[1:0];
  wire [1:0]  bright_grp = membership[3:2];
  wire [15:0] grp_mask   = {d3, d2};
  wire        node_hit   = (d1[5:0] == node_num);
  wire        grp_hit    = grp_mask[membership];
  wire        mixed_hit  = d1[lwd_pkg::BIT_BROAD] ? node_hit : grp_hit;
  wire        node_pfx   = (d1[7:6] == lwd_pkg::PAIR_ONES);
  wire [3:0]  short_sel  = d4[3:0];
  wire [3:0]  bright_sel = d1[7:4];

  wire is_full   = (id_q == lwd_pkg::ID_FULL_COLOR);
  wire is_short  = (id_q == lwd_pkg::ID_SHORT_COLOR);
  wire is_bright = (id_q == lwd_pkg::ID_BRIGHT);
  wire is_diag   = (id_q == lwd_pkg::ID_CAL_DIAG);
  wire is_off    = (id_q == lwd_pkg::ID_CAL_OFF);
  wire is_otp    = (id_q == lwd_pkg::ID_OTP_WRITE);
  wire is_ctrl   = (id_q == lwd_pkg::ID_LED_CTRL);

  // constant bits of each frame
  wire fmt_ok =
      (is_full   & d1[lwd_pkg::BIT_ONE] & d5[lwd_pkg::BIT_CONST4])
    | (is_ctrl   & d1[lwd_pkg::BIT_ONE] & d4[lwd_pkg::BIT_CONST0])
    | (is_short  & (d4[7:4] == lwd_pkg::NIB_ONES))
    | (is_bright & (d2[7:6] == lwd_pkg::PAIR_ONES))
    | (is_diag   & node_pfx)
    | (is_off    & node_pfx & (d8 == lwd_pkg::BYTE_ONES))
    | (is_otp    & node_pfx & (d2 == lwd_pkg::BYTE_ONES)
                 & (d3[7:4] == lwd_pkg::NIB_ONES));
  // short and brightness writes are matched on group only
  wire addr_hit =
      ((is_full | is_ctrl) & mixed_hit)
    | (is_short  & short_sel[color_grp])
    | (is_bright & bright_sel[bright_grp])
    | ((is_diag | is_off | is_otp) & node_hit);

  wire in_exec   = (state_q == lwd_pkg::ST_EXEC);
  wire frame_bad = in_exec & ctrl_en_q & ~(chk_ok_q & fmt_ok);
  wire exec_go   = in_exec & ctrl_en_q & chk_ok_q & fmt_ok & addr_hit;

  wire [1:0] mode      = d4[7:6];
  wire       m_now     = (mode == lwd_pkg::MODE_NOW);
  wire       m_store   = (mode == lwd_pkg::MODE_STORE);
  wire       m_apply   = (mode == lwd_pkg::MODE_APPLY);
  // discard code leaves LED state untouched; only the status counters see the frame
  wire do_store    = exec_go & (is_short | (is_full & (m_now | m_store)));
  wire do_color    = exec_go & (is_short | (is_full & (m_now | m_apply)));
  wire do_settings = exec_go & is_full & (m_now | m_apply);
  wire use_stored  = is_full & m_apply;

  wire [7:0] rx_c1 = is_short ? d1 : d6;
  wire [7:0] rx_c2 = is_short ? d2 : d7;
  wire [7:0] rx_c3 = is_short ? d3 : d8;
  wire [7:0] c1 = use_stored ? color_q[0] : rx_c1;
  wire [7:0] c2 = use_stored ? color_q[1] : rx_c2;
  wire [7:0] c3 = use_stored ? color_q[2] : rx_c3;
  wire [10:0] cal1 = cal_row(coef_q[0], coef_q[1], coef_q[2], c1, c2, c3);
  wire [10:0] cal2 = cal_row(coef_q[3], coef_q[4], coef_q[5], c1, c2, c3);
  wire [10:0] cal3 = cal_row(coef_q[6], coef_q[7], coef_q[8], c1, c2, c3);
  wire [10:0] mod1_d = cal_en_q ? cal1 : {3'h0, c1};
  wire [10:0] mod2_d = cal_en_q ? cal2 : {3'h0, c2};
  wire [10:0] mod3_d = cal_en_q ? cal3 : {3'h0, c3};

  // frame reception; a break always restarts, so a truncated frame is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q  <= lwd_pkg::ST_IDLE;
      id_q     <= 8'h00;
      len_q    <= 4'h0;
      cnt_q    <= 4'h0;
      sum_q    <= 8'h00;
      chk_ok_q <= 1'b0;
      for (int i = 0; i < lwd_pkg::BUF_DEPTH; i++) buf_q[i] <= 8'h00;
    end else if (rx_break) begin
      state_q <= lwd_pkg::ST_IDENT;
    end else begin
      unique case (state_q)
        lwd_pkg::ST_IDLE: state_q <= lwd_pkg::ST_IDLE;
        lwd_pkg::ST_IDENT: if (rx_valid) begin
          id_q    <= rx_byte;
          len_q   <= len_of(rx_byte);
          cnt_q   <= 4'h0;
          sum_q   <= 8'h00;
          state_q <= (len_of(rx_byte) == lwd_pkg::LEN_NONE) ? lwd_pkg::ST_IDLE
                                                             : lwd_pkg::ST_DATA;
        end
        lwd_pkg::ST_DATA: if (rx_valid) begin
          if (cnt_q == len_q) begin
            chk_ok_q <= (csum_add(sum_q, rx_byte) == lwd_pkg::CSUM_GOOD);
            state_q  <= lwd_pkg::ST_EXEC;
          end else begin
            buf_q[cnt_q[2:0]] <= rx_byte;
            sum_q <= csum_add(sum_q, rx_byte);
            cnt_q <= cnt_q + 4'h1;
          end
        end
        lwd_pkg::ST_EXEC: state_q <= lwd_pkg::ST_IDLE;
      endcase
    end
  end

  // OTP array; programming can only set bits, as a fuse would
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < lwd_pkg::OTP_DEPTH; i++) otp_q[i] <= lwd_pkg::OTP_DEFAULT[i];
      otp_stb_q  <= 1'b0;
      otp_addr_q <= 4'h0;
      otp_data_q <= 8'h00;
    end else begin
      otp_stb_q <= exec_go & is_otp;
      if (exec_go & is_otp) begin
        otp_q[d3[3:0]] <= otp_q[d3[3:0]] | d4;
        otp_addr_q     <= d3[3:0];
        otp_data_q     <= d4;
      end
    end
  end

  // coefficients: defaults from OTP in the first cycle after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_q <= 1'b1;
      for (int i = 0; i < lwd_pkg::NUM_COEF; i++) coef_q[i] <= 8'h00;
    end else if (load_q) begin
      load_q <= 1'b0;
      for (int i = 0; i < lwd_pkg::NUM_COEF; i++)
        coef_q[i] <= otp_q[lwd_pkg::OTP_COEF_BASE + 4'(i)];
    end else if (exec_go & is_diag) begin
      coef_q[0] <= d2;
      coef_q[4] <= d3;
      coef_q[8] <= d4;
    end else if (exec_go & is_off) begin
      coef_q[1] <= d2;
      coef_q[2] <= d3;
      coef_q[3] <= d4;
      coef_q[5] <= d5;
      coef_q[6] <= d6;
      coef_q[7] <= d7;
    end
  end

  // LED state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) color_q[i] <= 8'h00;
      mod1_q <= 11'h000;
      mod2_q <= 11'h000;
      mod3_q <= 11'h000;
      led_en_q <= 3'h0;
      cal_en_q <= 1'b0;
      mfreq_q <= 1'b0;
      out_on_q <= 1'b0;
      therm_q <= 1'b0;
      int_q <= 4'h0;
      ftime_q <= 6'h00;
      fade_en_q <= 1'b0;
      fade_lin_q <= 1'b0;
    end else begin
      if (do_store) begin
        color_q[0] <= rx_c1;
        color_q[1] <= rx_c2;
        color_q[2] <= rx_c3;
      end
      if (do_color) begin
        mod1_q <= mod1_d;
        mod2_q <= mod2_d;
        mod3_q <= mod3_d;
      end
      if (do_settings) begin
        ftime_q    <= d4[5:0];
        fade_en_q  <= d5[lwd_pkg::BIT_FADE_EN];
        fade_lin_q <= d5[lwd_pkg::BIT_FADE_LIN];
        out_on_q   <= d5[lwd_pkg::BIT_OUT_ON];
        int_q      <= d5[3:0];
      end
      if (exec_go & is_bright) begin
        int_q   <= d1[3:0];
        ftime_q <= d2[5:0];
      end
      if (exec_go & is_ctrl) begin
        cal_en_q <= d4[lwd_pkg::BIT_CAL_EN];
        mfreq_q  <= d4[lwd_pkg::BIT_MODFREQ];
        out_on_q <= d4[lwd_pkg::BIT_OUT_ON];
        therm_q  <= d4[lwd_pkg::BIT_THERMAL];
        led_en_q <= d4[3:1];
      end
    end
  end

  // status counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_cnt_q <= 8'h00;
      rej_cnt_q <= 8'h00;
      last_id_q <= 8'h00;
    end else begin
      if (exec_go) acc_cnt_q <= acc_cnt_q + 8'h01;
      if (frame_bad) rej_cnt_q <= rej_cnt_q + 8'h01;
      if (exec_go) last_id_q <= id_q;
    end
  end

  // AXI4-Lite slave: one write and one read at a time
  wire aw_hs   = awvalid & awready_q;
  wire w_hs    = wvalid & wready_q;
  wire do_wr   = ~awready_q & ~wready_q & ~bvalid_q;
  wire wr_ctrl = (awaddr_q == lwd_pkg::REG_CTRL);
  wire wr_ok   = wr_ctrl | (awaddr_q == lwd_pkg::REG_STATUS);
  wire ar_hs   = arvalid & arready_q;
  wire [31:0] rd_word = (araddr == lwd_pkg::REG_CTRL)   ? {31'h0, ctrl_en_q} :
                        {8'h00, last_id_q, rej_cnt_q, acc_cnt_q};
  wire rd_ok = (araddr == lwd_pkg::REG_CTRL) | (araddr == lwd_pkg::REG_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= lwd_pkg::RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      ctrl_en_q <= lwd_pkg::CTRL_RESET;
    end else begin
      if (aw_hs) begin
        awready_q <= 1'b0;
        awaddr_q  <= awaddr;
      end
      if (w_hs) begin
        wready_q <= 1'b0;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? lwd_pkg::RESP_OKAY : lwd_pkg::RESP_SLVERR;
        if (wr_ctrl & wstrb_q[0]) ctrl_en_q <= wdata_q[0];
      end
      if (bvalid_q & bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= lwd_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_ok ? rd_word : 32'h0000_0000;
      rresp_q   <= rd_ok ? lwd_pkg::RESP_OKAY : lwd_pkg::RESP_SLVERR;
    end else if (rvalid_q & rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign led_mod_1 = mod1_q;
  assign led_mod_2 = mod2_q;
  assign led_mod_3 = mod3_q;
  assign led_enable = led_en_q;
  assign cal_enable = cal_en_q;
  assign modulation_frequency_select = mfreq_q;
  assign outputs_on = out_on_q;
  assign thermal_control = therm_q;
  assign intensity = int_q;
  assign fade_time = ftime_q;
  assign fade_enable = fade_en_q;
  assign fade_linear = fade_lin_q;
  assign otp_prog_strobe = otp_stb_q;
  assign otp_prog_addr = otp_addr_q;
  assign otp_prog_data = otp_data_q;
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  a_bad_frame_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    (in_exec & ~chk_ok_q) |=> ($stable(mod1_q) && $stable(out_on_q) && $stable(cal_en_q)))
    else $error("frame with bad checksum changed LED state");
  a_store_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec_go & is_full & m_store) |=> ($stable(mod2_q) && color_q[1] == $past(d7)))
    else $error("store-only write changed modulation or missed store");
  a_raw_color: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec_go & is_short & ~cal_en_q) |=> (mod1_q == {3'h0, $past(d1)}))
    else $error("uncalibrated short write not passed through");
  a_cal_color: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec_go & is_full & m_now & cal_en_q) |=> (mod3_q == $past(cal3)))
    else $error("calibrated color not taken from matrix");
  a_reset_coef: assert property (@(posedge aclk) disable iff (!aresetn)
    load_q |=> (!load_q && coef_q[0] == $past(otp_q[lwd_pkg::OTP_COEF_BASE])))
    else $error("coefficient default not loaded from OTP");
  a_group_miss: assert property (@(posedge aclk) disable iff (!aresetn)
    (in_exec & is_ctrl & ~d1[lwd_pkg::BIT_BROAD] & ~grp_hit) |=> $stable(led_en_q))
    else $error("group write acted without membership match");
  a_node_miss: assert property (@(posedge aclk) disable iff (!aresetn)
    (in_exec & is_diag & ~node_hit & ~load_q) |=> $stable(coef_q[4]))
    else $error("node write acted on foreign node number");
  a_otp_program: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec_go & is_otp) |=> (otp_stb_q && (otp_q[otp_addr_q] & otp_data_q) == otp_data_q))
    else $error("OTP byte not programmed");
  a_ctrl_now: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec_go & is_ctrl) |=> (led_en_q == $past(d4[3:1]) && out_on_q == $past(d4[5])))
    else $error("LED control write not applied at once");
endmodule

/* File: tb/lwd_lm.sv */
/* LIN master model: sends one write frame, classic checksum at the end.
   Assumes the decoder samples rx_* on the rising edge of aclk. */
`timescale 1ns/1ps
module lwd_lm (
  input  wire logic  aclk,
  output logic       rx_break,
  output logic       rx_valid,
  output logic [7:0] rx_byte
);
  initial begin
    rx_break = 0;
    rx_valid = 0;
    rx_byte = 0;
  end
  // bad spoils the checksum; a released line shows the inverse of its last byte
  task automatic send(input logic [7:0] id, input logic [63:0] d, input int n, input logic bad);
    int s;
    s = 0;
    @(posedge aclk) rx_break <= 1;
    @(posedge aclk);
    rx_break <= 0;
    rx_valid <= 1;
    rx_byte <= id;
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      rx_byte <= d[63-8*i -: 8];
      s += d[63-8*i -: 8];
      if (s > 255) s -= 255;
    end
    @(posedge aclk);
    rx_byte <= ~s[7:0] ^ {8{bad}};
    @(posedge aclk);
    rx_valid <= 0;
    rx_byte <= s[7:0] ^ {8{bad}};
    repeat (3) @(posedge aclk);
  endtask
endmodule

/* File: tb/tb.sv */
/* Bench for the write frame decoder: frames from the master model, registers
   over AXI4-Lite. Assumes blank OTP after reset: node 0, membership 0. */
`timescale 1ns/1ps
module tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, cal_enable;
  logic        outputs_on, fade_enable, fade_linear, rx_break, rx_valid;
  logic        modulation_frequency_select, thermal_control, otp_prog_strobe;
  logic [7:0]  rx_byte, awaddr, araddr, otp_prog_data;
  logic [31:0] wdata, rdata, v;
  logic [10:0] led_mod_1, led_mod_2, led_mod_3;
  logic [3:0]  wstrb, intensity, otp_prog_addr;
  logic [5:0]  fade_time;
  logic [2:0]  led_enable;
  logic [1:0]  bresp, rresp, r, b;
  int          n_mismatch, num_checks, cyc, n_stb;
  lwd_decoder lwd_decoder_i (
    .aclk(aclk), .aresetn(aresetn), .rx_break(rx_break), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .led_mod_1(led_mod_1), .led_mod_2(led_mod_2),
    .led_mod_3(led_mod_3), .led_enable(led_enable), .cal_enable(cal_enable),
    .modulation_frequency_select(modulation_frequency_select),
    .outputs_on(outputs_on), .thermal_control(thermal_control),
    .intensity(intensity), .fade_time(fade_time), .fade_enable(fade_enable),
    .fade_linear(fade_linear), .otp_prog_strobe(otp_prog_strobe),
    .otp_prog_addr(otp_prog_addr), .otp_prog_data(otp_prog_data),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  lwd_lm lwd_lm_i (.aclk(aclk), .rx_break(rx_break), .rx_valid(rx_valid), .rx_byte(rx_byte));
  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    // the strobe stands one cycle only, so it is counted where it stands
    if (otp_prog_strobe) n_stb <= n_stb + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!(bvalid && bready));
    b = bresp;
    bready <= 0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end while (!(rvalid && rready));
    v = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task automatic fc(input logic [63:0] d);
    lwd_lm_i.send(8'h64, d, 8, 0);
  endtask
  task automatic t_color();
    fc(64'hC000_0005_FA12_3456);
    chk("mod1", led_mod_1, 32'h0000_0012);
    chk("mod2", led_mod_2, 32'h0000_0034);
    chk("mod3", led_mod_3, 32'h0000_0056);
    chk("ctl", {fade_enable, fade_linear, outputs_on, intensity, fade_time}, 32'h1E85);
  endtask
  task automatic t_regs();
    axr(lwd_pkg::REG_STATUS);
    chk("status", v[23:0], 32'h0064_0001);
    axr(8'h08);
    chk("resp", r, lwd_pkg::RESP_SLVERR);
    axw(8'h0C, 32'h0000_0000);
    chk("bresp_bad", b, lwd_pkg::RESP_SLVERR);
    axw(lwd_pkg::REG_CTRL, 32'h0000_0000);
    chk("bresp", b, lwd_pkg::RESP_OKAY);
    fc(64'hC000_0005_FA55_5555);
    chk("off", led_mod_1, 32'h0000_0012);
    axw(lwd_pkg::REG_CTRL, 32'h0000_0001);
  endtask
  task automatic t_reject();
    lwd_lm_i.send(8'h64, 64'hC000_0005_FA77_7777, 8, 1);
    fc(64'hC000_00C5_FA77_7777);
    fc(64'hC000_0005_EA77_7777);
    chk("mod1", led_mod_1, 32'h0000_0012);
    fc(64'hC000_0045_FA44_4444);
    chk("store", led_mod_1, 32'h0000_0012);
    fc(64'hC000_0085_FA00_0000);
    chk("apply", led_mod_1, 32'h0000_0044);
  endtask
  task automatic t_group();
    fc(64'h7F01_0005_FA31_3131);
    fc(64'h7F02_0005_FA32_3232);
    fc(64'hC100_0005_FA33_3333);
    chk("grp", led_mod_1, 32'h0000_0031);
    lwd_lm_i.send(8'h6F, 64'h2122_23F1_0000_0000, 4, 0);
    lwd_lm_i.send(8'h6F, 64'h5555_55F2_0000_0000, 4, 0);
    chk("short", led_mod_1, 32'h0000_0021);
    lwd_lm_i.send(8'h2E, 64'h13C7_0000_0000_0000, 2, 0);
    lwd_lm_i.send(8'h2E, 64'h29C9_0000_0000_0000, 2, 0);
    chk("bright", {intensity, fade_time}, 32'h0000_00C7);
  endtask
  task automatic t_cal();
    lwd_lm_i.send(8'hA3, 64'hC000_00FF_0000_0000, 4, 0);
    chk("ctrl", {cal_enable, led_enable}, 32'h0000_000F);
    chk("ctrl2", {modulation_frequency_select, thermal_control}, 32'h0000_0003);
    // group-addressed control write whose mask misses our membership
    lwd_lm_i.send(8'hA3, 64'h4002_0001_0000_0000, 4, 0);
    chk("grp_ctrl", {cal_enable, led_enable}, 32'h0000_000F);
    lwd_lm_i.send(8'h25, 64'hC0FF_8080_0000_0000, 4, 0);
    // foreign node number: coefficients must survive
    lwd_lm_i.send(8'h25, 64'hC100_0000_0000_0000, 4, 0);
    fc(64'hC000_0005_FA40_0000);
    chk("cal", led_mod_1, 32'h0000_007F);
    lwd_lm_i.send(8'hE7, 64'hC0FF_F53C_0000_0000, 4, 0);
    chk("otp", {otp_prog_addr, otp_prog_data}, 32'h0000_053C);
    chk("otp_stb", n_stb, 32'h0000_0001);
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 0;
    {awaddr, araddr, wdata} = 0;
    wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    t_color();
    t_regs();
    t_reject();
    t_group();
    t_cal();
    close_out();
  end
endmodule
